//--- design/sadc_top.sv
`timescale 1ns/1ps
module sadc_top #(
	parameter logic [1:0] VARIANT = sadc_pkg::VAR_100K
) (
	// System clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// Link pins
	input wire logic SCK,
	input wire logic CONVERT_START,
	input wire logic SERIAL_CHAIN_IN,
	// Sampled analog value as a digital code
	input wire logic [sadc_pkg::RES_BITS-1:0] SAMPLE_CODE,
	// Serial output pin
	output logic SERIAL_RESULT_OUT,
	output logic SERIAL_RESULT_OE_N,
	// Status
	output logic CONV_BUSY
);
	localparam int CONV_CYC = (VARIANT == sadc_pkg::VAR_100K) ? sadc_pkg::CONV_100K_CYC
		: (VARIANT == sadc_pkg::VAR_500K_B) ? sadc_pkg::CONV_500K_B_CYC
		: sadc_pkg::CONV_500K_C_CYC; // see (R1) see (R2)
	initial begin
		if (VARIANT > sadc_pkg::VAR_500K_C) begin
			$error("unsupported variant");
		end
	end
	logic cnv_s;
	logic cnv_prev_q;
	logic [10:0] cnt_q;
	sadc_pkg::sadc_result_s res_q;
	logic [sadc_pkg::RES_BITS-1:0] code_q;
	logic sdo_w;
	logic oe_n_w;
	logic sdi_s;
	logic out_clr_n;
	sadc_sync u_sync_cnv (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.din(CONVERT_START),
		.dout(cnv_s)
	);
	sadc_sync u_sync_sdi (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.din(SERIAL_CHAIN_IN),
		.dout(sdi_s)
	);

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			cnv_prev_q <= 1'b0;
		end else begin
			cnv_prev_q <= cnv_s;
		end
	end

	// Mode and sample taken at convert_start rise
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			res_q <= '0;
			code_q <= '0;
		end else if (cnv_s && !cnv_prev_q) begin
			res_q.chain <= !sdi_s; // see (R12)
			code_q <= SAMPLE_CODE;
		end else if (cnt_q == 11'(1)) begin
			res_q.data <= code_q; // see (R13)
		end
	end

	// Conversion timer
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_q <= 11'h0;
			CONV_BUSY <= 1'b0;
		end else if (cnv_s && !cnv_prev_q) begin
			// Margin covers sync and edge-detect delay from the pin
			cnt_q <= 11'(CONV_CYC - 6);
			CONV_BUSY <= 1'b1;
		end else if (cnt_q != 11'h0) begin
			cnt_q <= cnt_q - 11'h1;
			CONV_BUSY <= (cnt_q != 11'h1); // see (R1) see (R2)
		end
	end

	// Result word held stable between conversions; quasi-static crossing
	sadc_link u_link (
		.sck(SCK),
		.rst_n(NRST),
		.convert_start(CONVERT_START),
		.serial_chain_in(SERIAL_CHAIN_IN),
		.chain(res_q.chain),
		.word(res_q.data),
		.serial_result_out(sdo_w),
		.sdo_oe_n(oe_n_w)
	);

	// Pin released at once on deselect, even with SCK stopped
	assign out_clr_n = NRST && !(res_q.chain ? !CONVERT_START
		: (CONVERT_START && SERIAL_CHAIN_IN)); // see (R5) see (R14)
	always_ff @(negedge SCK or negedge out_clr_n) begin
		if (!out_clr_n) begin
			SERIAL_RESULT_OUT <= 1'b0;
			SERIAL_RESULT_OE_N <= 1'b1;
		end else begin
			SERIAL_RESULT_OUT <= sdo_w;
			SERIAL_RESULT_OE_N <= oe_n_w;
		end
	end
endmodule : sadc_top

//--- design/sadc_pkg.sv
// Overview of operation
// (R1) 100k variant result ready within 9.5 us
// (R2) 500k variant ready 1.6 us B, 1.2 us C
// (R3) Host holds convert_start high at least 500 ns
// (R4) Select mode: result_msb out when start/input low; code puts it on the pin only after the first serial falling edge
// (R5) Select mode: release output on high or word end
// (R6) Advance bit after each serial falling edge
// (R7) Host keeps chain input stable at start edge
// (R8) Chain mode: host holds serial clock stable at start
// (R9) Chain mode: input taken on serial falling edges
// (R10) Select mode serial period at least 10.5/22 ns
// (R11) Chain mode serial period at least 11.5/23 ns
// (R12) Chain mode when input low; 16-cycle forwarding delay
// (R13) 16-bit straight binary, no pipeline latency
// (R14) Select mode drives only while convert_start low; code also drives with convert_start high while input low
// (R15) Host spaces conversions by minimum cycle time
package sadc_pkg;
	localparam int RES_BITS = 16;
	localparam int SYS_CLK_MHZ = 100;
	localparam int T_CONV_100K_NS = 9500;
	localparam int T_CONV_500K_B_NS = 1600;
	localparam int T_CONV_500K_C_NS = 1200;
	// Longest times round down to whole cycles
	localparam int CONV_100K_CYC = T_CONV_100K_NS * SYS_CLK_MHZ / 1000;
	localparam int CONV_500K_B_CYC = T_CONV_500K_B_NS * SYS_CLK_MHZ / 1000;
	localparam int CONV_500K_C_CYC = T_CONV_500K_C_NS * SYS_CLK_MHZ / 1000;
	localparam logic [1:0] VAR_100K = 2'h0;
	localparam logic [1:0] VAR_500K_B = 2'h1;
	localparam logic [1:0] VAR_500K_C = 2'h2;
	typedef struct packed {
		logic [RES_BITS-1:0] data;
		logic chain;
	} sadc_result_s;
endpackage : sadc_pkg

//--- design/sadc_sync.sv
`timescale 1ns/1ps
module sadc_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level
	input wire logic din,
	output logic dout
);
	logic [2:0] s_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= 3'h0;
		end else begin
			s_q <= {s_q[1:0], din};
		end
	end
	// Change counts when second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 1'b0;
		end else if (s_q[1] == s_q[2]) begin
			dout <= s_q[2];
		end
	end
endmodule : sadc_sync

//--- design/sadc_link.sv
`timescale 1ns/1ps
module sadc_link (
	// Link clock, async reset
	input wire logic sck,
	input wire logic rst_n,
	// Select and mode
	input wire logic convert_start,
	input wire logic serial_chain_in,
	input wire logic chain,
	// Result word from core domain
	input wire logic [sadc_pkg::RES_BITS-1:0] word,
	// Serial out
	output logic serial_result_out,
	output logic sdo_oe_n
);
	logic [sadc_pkg::RES_BITS-1:0] sh_q;
	logic [4:0] cnt_q;
	logic started_q;
	logic sel;
	logic frm_clr_n;
	// Select mode: chosen by low start or low input
	assign sel = !chain && !(convert_start && serial_chain_in); // see (R4) see (R14)
	// Frame ends without sck edges, since sck stands still between frames
	assign frm_clr_n = rst_n && !(chain ? !convert_start : (convert_start && serial_chain_in)); // see (R5) see (R14)
	always_ff @(negedge sck or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= '0;
		end else if (chain) begin
			sh_q <= {sh_q[sadc_pkg::RES_BITS-2:0], serial_chain_in}; // see (R9) see (R12)
		end else if (sel && !started_q) begin
			sh_q <= {word[sadc_pkg::RES_BITS-2:0], 1'b0}; // see (R6)
		end else if (sel && cnt_q < 5'(sadc_pkg::RES_BITS)) begin
			sh_q <= {sh_q[sadc_pkg::RES_BITS-2:0], 1'b0}; // see (R6)
		end
	end
	// Deselect reloads the word on next frame
	always_ff @(negedge sck or negedge frm_clr_n) begin
		if (!frm_clr_n) begin
			cnt_q <= 5'h0;
			started_q <= 1'b0;
		end else if (chain) begin
			started_q <= 1'b0;
		end else if (!sel) begin
			started_q <= 1'b0;
			cnt_q <= 5'h0;
		end else if (!started_q) begin
			cnt_q <= 5'h1;
			started_q <= 1'b1;
		end else if (cnt_q < 5'(sadc_pkg::RES_BITS)) begin
			cnt_q <= cnt_q + 5'h1;
		end
	end
	// MSB on link output before first falling edge, at the pin only after it
	assign serial_result_out = (started_q || chain) ? sh_q[sadc_pkg::RES_BITS-1]
		: word[sadc_pkg::RES_BITS-1]; // see (R4)
	// Release after the last falling edge of the word
	assign sdo_oe_n = !(chain || (sel && cnt_q < 5'(sadc_pkg::RES_BITS))); // see (R5)
endmodule : sadc_link

//--- tb/sadc_host.sv
`timescale 1ns/1ps
module sadc_host (
	// Gate and pins
	input wire logic run,
	input wire logic serial_result_out,
	input wire logic oe_n,
	output logic sck,
	output logic [15:0] word_q
);
	// Link clock stands still between frames
	initial begin
		sck = 1'b0;
		forever #40 sck = run & ~sck;
	end
	always @(negedge sck) if (!oe_n) word_q <= {word_q[14:0], serial_result_out};
endmodule : sadc_host

//--- tb/sadc_sva.sv
`timescale 1ns/1ps
module sadc_sva #(parameter logic [1:0] VARIANT = 2'h0) (
	// Clocks and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic SCK,
	// Pins
	input wire logic CONVERT_START,
	input wire logic SERIAL_CHAIN_IN,
	input wire logic [15:0] SAMPLE_CODE,
	input wire logic SERIAL_RESULT_OUT,
	input wire logic SERIAL_RESULT_OE_N,
	input wire logic CONV_BUSY
);
	localparam int CMAX = VARIANT == 2'h0 ? 950 : VARIANT == 2'h1 ? 160 : 120;
	wire cs = CONVERT_START;
	wire di = SERIAL_CHAIN_IN;
	wire so = SERIAL_RESULT_OUT;
	wire oe_n = SERIAL_RESULT_OE_N;
	logic sel_q;
	always_ff @(posedge cs or negedge NRST) if (!NRST) sel_q <= 1'b0; else sel_q <= di;
	a_busy_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(cs) |-> ##[1:5] CONV_BUSY) else $error("busy late");
	a_conv_time: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(cs) |-> ##[5:CMAX] !CONV_BUSY) else $error("slow");
	a_busy_cause: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(CONV_BUSY) |-> $past(cs, 2)) else $error("busy");
	a_hiz_high: assert property (@(negedge SCK) disable iff (!NRST)
		sel_q && cs && di |=> oe_n) else $error("driven");
	a_msb_first: assert property (@(negedge SCK) disable iff (!NRST)
		sel_q && $fell(oe_n) |-> so == SAMPLE_CODE[15]) else $error("msb");
	a_next_bit: assert property (@(negedge SCK) disable iff (!NRST)
		sel_q && $fell(oe_n) |=> so == SAMPLE_CODE[14] ##1 so == SAMPLE_CODE[13]) else $error("bit");
	a_word_end: assert property (@(negedge SCK) disable iff (!NRST)
		sel_q && $fell(oe_n) |-> !oe_n [*8] ##9 oe_n) else $error("length");
	a_chain_fwd: assert property (@(negedge SCK) disable iff (!NRST)
		!sel_q && !oe_n && !$past(oe_n, 17) |-> so == $past(di, 17)) else $error("chain");
endmodule : sadc_sva
bind sadc_top sadc_sva #(.VARIANT(VARIANT)) u_sva (.SYS_CLK, .NRST, .SCK, .CONVERT_START,
	.SERIAL_CHAIN_IN, .SAMPLE_CODE, .SERIAL_RESULT_OUT, .SERIAL_RESULT_OE_N, .CONV_BUSY);

//--- tb/sar_adc_serial_readout_tb.sv
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
	logic clk, rst_n, convert_start, serial_chain_in, run, sck, serial_result_out, oe_n, busy;
	logic [15:0] code, word;
	int error_cnt, n_compared, cyc;
	sadc_top uut (.SYS_CLK(clk), .NRST(rst_n), .SCK(sck), .CONVERT_START(convert_start),
		.SERIAL_CHAIN_IN(serial_chain_in), .SAMPLE_CODE(code), .SERIAL_RESULT_OUT(serial_result_out),
		.SERIAL_RESULT_OE_N(oe_n), .CONV_BUSY(busy));
	sadc_host u_host (.run(run), .serial_result_out(serial_result_out), .oe_n(oe_n), .sck(sck), .word_q(word));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (++cyc > 20000) begin
		error_cnt++;
		end_sim();
	end
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic start(logic [15:0] c, logic m);
		code <= c;
		serial_chain_in <= m;
		@(posedge clk) convert_start <= 1'b1;
		repeat (8) @(posedge clk);
		for (int t = 0; t < 999 && busy !== 1'b0; t++) @(posedge clk);
	endtask : start
	task automatic sel_read(logic [15:0] c);
		start(c, 1'b1);
		convert_start <= 1'b0;
		run <= 1'b1;
		repeat (200) @(posedge clk);
		run <= 1'b0;
		repeat (100) @(posedge clk);
		chk("sel_word", word, c);
	endtask : sel_read
	task automatic chain_read();
		start(16'hA5C3, 1'b0);
		serial_chain_in <= 1'b1;
		run <= 1'b1;
		repeat (320) @(posedge clk);
		run <= 1'b0;
		convert_start <= 1'b0;
		repeat (100) @(posedge clk);
		chk("chain_word", word, 16'hFFFF);
	endtask : chain_read
	initial begin
		rst_n = 1'b0;
		convert_start = 1'b0;
		serial_chain_in = 1'b1;
		run = 1'b0;
		code = 16'h0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		chain_read();
		sel_read(16'h8001);
		sel_read(16'h7FFE);
		end_sim();
	end
endmodule : sar_adc_serial_readout_tb
